/* bench/inset_window_geometry_regs_tb.sv */
// Purpose: Self-checking bench for the inset geometry register bank
// Assumes: Bus tasks are entered just after a rising clock edge
// Notes: Expected bytes and geometry are worked out here from the register map

`timescale 1ns/1ps
`default_nettype none

module inset_window_geometry_regs_tb;
  // ==========================================================
  // Signals
  localparam int LIM = 40;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, inset_sel;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  inset_geom_pkg::geom_t geom [2];
  int fails = 0;
  int num_checks = 0;
  logic [7:0] idx_tab [8] = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39};
  logic [7:0] mask_tab [8] = '{8'hfc, 8'h1f, 8'hfc, 8'h1f, 8'hff, 8'h1f, 8'hfc, 8'h07};
  // Image width 4092 stays moderate and plus x offset 4092 stays under 8188
  // There is no window height register, so y offset 8191 stays in range
  logic [7:0] val_tab [8] = '{8'hff, 8'hef, 8'hff, 8'hef, 8'hff, 8'hff, 8'hff, 8'hff};

  always #25 sys_clk = ~sys_clk;

  inset_window_geometry_regs #(.ADDR_W(12), .NUM_INSETS(2)) dut_u (
    .sys_clk(sys_clk), .nrst(nrst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .inset_sel(inset_sel),
    .inset_geom(geom)
  );

  // ==========================================================
  // Checking and closing
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic check_geom(input int k, input logic [12:0] iw, input logic [12:0] ox,
                            input logic [12:0] oy, input logic [10:0] ww);
    check("img_w", {19'h0, geom[k].img_w}, {19'h0, iw});
    check("off_x", {19'h0, geom[k].off_x}, {19'h0, ox});
    check("off_y", {19'h0, geom[k].off_y}, {19'h0, oy});
    check("win_w", {21'h0, geom[k].win_w}, {21'h0, ww});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Bus tasks: hold each channel until its own handshake edge
  task automatic bus_write(input logic [7:0] idx, input logic [7:0] val, input logic [3:0] strb,
                           output logic [1:0] bresp);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    bresp = 2'h3;
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, val};
    s_axi_wstrb <= strb;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done)
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid === 1'b1)
      begin
        bresp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
      if (!done && n == LIM)
      begin
        fails++;
        close_out();
      end
    end
    // Let an edge pass so the next call never re-raises bready in this step
    @(posedge sys_clk);
  endtask

  task automatic bus_read(input logic [7:0] idx, output logic [31:0] data,
                          output logic [1:0] rresp);
    int n;
    bit done;
    n = 0;
    done = 1'b0;
    data = 32'h0;
    rresp = 2'h3;
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done)
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid === 1'b1)
      begin
        data = s_axi_rdata;
        rresp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
      if (!done && n == LIM)
      begin
        fails++;
        close_out();
      end
    end
    // Let an edge pass so the next call never re-raises rready in this step
    @(posedge sys_clk);
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    check("select after reset", {31'h0, inset_sel}, 32'h0);
    check_geom(0, 13'h0, 13'h0, 13'h0, 11'h0);
    check_geom(1, 13'h0, 13'h0, 13'h0, 11'h0);
    for (int i = 0; i < 8; i++)
    begin
      bus_read(idx_tab[i], rd, resp);
      check("reset byte", rd, 32'h0);
    end
    $display("test reset values done");

    for (int i = 0; i < 8; i++)
    begin
      bus_write(idx_tab[i], val_tab[i], 4'hf, resp);
      check("write resp", {30'h0, resp}, 32'h0);
      bus_read(idx_tab[i], rd, resp);
      check("read resp", {30'h0, resp}, 32'h0);
      check("masked byte", rd, {24'h0, val_tab[i] & mask_tab[i]});
      if (idx_tab[i] == 8'h34)
        check("x staged only", {19'h0, geom[0].off_x}, 32'h0);
    end
    check_geom(0, 13'h0ffc, 13'h0ffc, 13'h1fff, 11'h7fc);
    check_geom(1, 13'h0, 13'h0, 13'h0, 11'h0);
    $display("test masks and staging done");

    bus_write(8'h40, 8'h01, 4'hf, resp);
    check("select set", {31'h0, inset_sel}, 32'h1);
    bus_read(8'h34, rd, resp);
    check("inset1 x low", rd, 32'h0);
    bus_write(8'h34, 8'h43, 4'hf, resp);
    bus_write(8'h35, 8'he1, 4'hf, resp);
    bus_write(8'h36, 8'h03, 4'hf, resp);
    bus_write(8'h37, 8'h02, 4'hf, resp);
    bus_write(8'h33, 8'h05, 4'hf, resp);
    bus_write(8'h38, 8'h11, 4'hf, resp);
    bus_write(8'h39, 8'h01, 4'hf, resp);
    check_geom(1, 13'h0500, 13'h0140, 13'h0203, 11'h110);
    check_geom(0, 13'h0ffc, 13'h0ffc, 13'h1fff, 11'h7fc);
    bus_write(8'h40, 8'h00, 4'hf, resp);
    bus_read(8'h34, rd, resp);
    check("inset0 x low", rd, 32'h0000_00fc);
    $display("test inset routing done");

    bus_write(8'h3a, 8'h55, 4'hf, resp);
    check("unmapped bresp", {30'h0, resp}, 32'h2);
    bus_read(8'h3a, rd, resp);
    check("unmapped rresp", {30'h0, resp}, 32'h2);
    check("unmapped rdata", rd, 32'h0);
    bus_write(8'h35, 8'h00, 4'h0, resp);
    check("no strobe bresp", {30'h0, resp}, 32'h0);
    check_geom(0, 13'h0ffc, 13'h0ffc, 13'h1fff, 11'h7fc);
    $display("test refusals done");
    close_out();
  end
endmodule

`default_nettype wire

/* logic/axil_chan_hold.sv */
// Purpose: One-slot holder for an AXI4-Lite address or data channel
// Assumes: clr is raised only while the slot is full
// Notes: Ready is a register, low while the slot holds an item

`timescale 1ns/1ps
`default_nettype none

module axil_chan_hold #(
  parameter int W = 8
) (
  input wire logic sys_clk, // register clock
  input wire logic nrst, // async reset, active low
  input wire logic in_valid, // channel valid
  output logic in_ready, // channel ready
  input wire logic [W-1:0] in_data, // channel payload
  input wire logic clr, // consume the held item
  output logic full, // an item is held
  output logic [W-1:0] data // held payload
);

  if (W < 1)
  begin : g_chk_w
    $error("W must be at least 1");
  end

  logic ready_q;
  logic ready_d;
  logic [W-1:0] data_q;
  logic [W-1:0] data_d;

  always_comb
  begin
    ready_d = ready_q;
    data_d = data_q;
    if (in_valid && ready_q)
    begin
      ready_d = 1'b0;
      data_d = in_data;
    end
    if (clr)
    begin
      ready_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ready_q <= 1'b1;
      data_q <= '0;
    end
    else
    begin
      ready_q <= ready_d;
      data_q <= data_d;
    end
  end

  assign in_ready = ready_q;
  assign full = !ready_q;
  assign data = data_q;

endmodule

`default_nettype wire

/* logic/inset_geom_pkg.sv */
// Purpose: Shared constants and types for the inset geometry register bank
// Assumes: Registers are byte wide, one per aligned 32-bit word
// Notes: Register indices are kept; byte address is four times the index

package inset_geom_pkg;

  // ==========================================================
  // Register indices
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  localparam int DATA_W = 32;
  localparam int STAGE_N = 8;
  localparam logic [7:0] IDX_BASE = 8'h32;
  localparam logic [7:0] IDX_IMG_W_LO = 8'h32;
  localparam logic [7:0] IDX_IMG_W_HI = 8'h33;
  localparam logic [7:0] IDX_OFFX_LO = 8'h34;
  localparam logic [7:0] IDX_OFFX_HI = 8'h35;
  localparam logic [7:0] IDX_OFFY_LO = 8'h36;
  localparam logic [7:0] IDX_OFFY_HI = 8'h37;
  localparam logic [7:0] IDX_WIN_W_LO = 8'h38;
  localparam logic [7:0] IDX_WIN_W_HI = 8'h39;
  localparam logic [7:0] IDX_SEL = 8'h40;

  // ==========================================================
  // Staging slots and writable bit masks
  localparam logic [2:0] SLOT_IMG_W_LO = 3'h0;
  localparam logic [2:0] SLOT_IMG_W_HI = 3'h1;
  localparam logic [2:0] SLOT_OFFX_LO = 3'h2;
  localparam logic [2:0] SLOT_OFFX_HI = 3'h3;
  localparam logic [2:0] SLOT_OFFY_LO = 3'h4;
  localparam logic [2:0] SLOT_OFFY_HI = 3'h5;
  localparam logic [2:0] SLOT_WIN_W_LO = 3'h6;
  localparam logic [2:0] SLOT_WIN_W_HI = 3'h7;
  localparam logic [7:0] STAGE_MASK [STAGE_N] = '{
    8'hfc, 8'h1f, 8'hfc, 8'h1f, 8'hff, 8'h1f, 8'hfc, 8'h07};
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int HI_W = 5;
  localparam int WW_HI_W = 3;
  localparam int SEL_BIT = 0;

  // ==========================================================
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [12:0] img_w;
    logic [12:0] off_x;
    logic [12:0] off_y;
    logic [10:0] win_w;
  } geom_t;

  typedef struct packed {
    logic en;
    logic [7:0] idx;
    logic [7:0] data;
  } wr_t;

  localparam geom_t GEOM_RST = '0;

endpackage

/* logic/inset_param_set.sv */
// Purpose: Staged bytes and applied geometry of one inset
// Assumes: wr is already routed to this inset
// Notes: Low bytes wait in staging until the matching high byte is written

`timescale 1ns/1ps
`default_nettype none

module inset_param_set (
  input wire logic sys_clk, // register clock
  input wire logic nrst, // async reset, active low
  input wire inset_geom_pkg::wr_t wr, // byte write for this inset
  input wire logic [7:0] rd_idx, // register index being read
  output logic [7:0] rd_byte, // staged byte at rd_idx
  output inset_geom_pkg::geom_t geom // applied geometry
);

  localparam int HW = inset_geom_pkg::HI_W;
  localparam int WW = inset_geom_pkg::WW_HI_W;

  logic [7:0] stage_q [inset_geom_pkg::STAGE_N];
  logic [7:0] stage_d [inset_geom_pkg::STAGE_N];
  inset_geom_pkg::geom_t geom_q;
  inset_geom_pkg::geom_t geom_d;
  logic [7:0] wr_off;
  logic [7:0] rd_off;
  logic wr_hit;

  assign wr_off = wr.idx - inset_geom_pkg::IDX_BASE;
  assign rd_off = rd_idx - inset_geom_pkg::IDX_BASE;
  assign wr_hit = wr.en && (wr.idx >= inset_geom_pkg::IDX_IMG_W_LO)
    && (wr.idx <= inset_geom_pkg::IDX_WIN_W_HI);

  // ==========================================================
  // Staging and apply
  always_comb
  begin
    stage_d = stage_q;
    geom_d = geom_q;
    if (wr_hit)
    begin
      // Tied and unused bits never store a one
      stage_d[wr_off[2:0]] = wr.data & inset_geom_pkg::STAGE_MASK[wr_off[2:0]];
      // Offsets count pixels from the inset image corner
      unique case (wr_off[2:0])
        inset_geom_pkg::SLOT_IMG_W_HI:
          geom_d.img_w = {HW'(stage_d[inset_geom_pkg::SLOT_IMG_W_HI]),
            stage_d[inset_geom_pkg::SLOT_IMG_W_LO]};
        inset_geom_pkg::SLOT_OFFX_HI:
          geom_d.off_x = {HW'(stage_d[inset_geom_pkg::SLOT_OFFX_HI]),
            stage_d[inset_geom_pkg::SLOT_OFFX_LO]};
        inset_geom_pkg::SLOT_OFFY_HI:
          geom_d.off_y = {HW'(stage_d[inset_geom_pkg::SLOT_OFFY_HI]),
            stage_d[inset_geom_pkg::SLOT_OFFY_LO]};
        inset_geom_pkg::SLOT_WIN_W_HI:
          geom_d.win_w = {WW'(stage_d[inset_geom_pkg::SLOT_WIN_W_HI]),
            stage_d[inset_geom_pkg::SLOT_WIN_W_LO]};
        default:
          geom_d = geom_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage_q <= '{default: inset_geom_pkg::RST_BYTE};
      geom_q <= inset_geom_pkg::GEOM_RST;
    end
    else
    begin
      stage_q <= stage_d;
      geom_q <= geom_d;
    end
  end

  assign rd_byte = stage_q[rd_off[2:0]];
  assign geom = geom_q;

endmodule

`default_nettype wire

/* logic/inset_window_geometry_regs.sv */
// Purpose: AXI4-Lite register bank for inset window geometry
// Assumes: One write and one read outstanding at most
// Notes: Two inset parameter sets, chosen by the select register

`timescale 1ns/1ps
`default_nettype none

module inset_window_geometry_regs #(
  parameter int ADDR_W = 12,
  parameter int NUM_INSETS = 2
) (
  input wire logic sys_clk, // 20 MHz register clock
  input wire logic nrst, // async reset, active low
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic inset_sel, // inset taking geometry writes
  output inset_geom_pkg::geom_t inset_geom [NUM_INSETS] // applied geometry
);

  // ==========================================================
  // Elaboration checks
  if (ADDR_W < inset_geom_pkg::IDX_LSB + inset_geom_pkg::IDX_W)
  begin : g_chk_addr
    $error("ADDR_W too small for the register indices");
  end
  if (NUM_INSETS != 2)
  begin : g_chk_insets
    $error("NUM_INSETS must be 2, the select is one bit");
  end

  typedef enum logic [1:0] {
    WS_IDLE = 2'b01,
    WS_RESP = 2'b10
  } wstate_t;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b01,
    RS_DATA = 2'b10
  } rstate_t;

  localparam int WBUS_W = 36;

  // ==========================================================
  // Channel holders
  logic aw_full;
  logic w_full;
  logic wr_clr;
  logic [ADDR_W-1:0] aw_addr;
  logic [WBUS_W-1:0] w_hold;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  axil_chan_hold #(
    .W(ADDR_W)
  ) u_aw_hold (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(s_axi_awvalid),
    .in_ready(s_axi_awready),
    .in_data(s_axi_awaddr),
    .clr(wr_clr),
    .full(aw_full),
    .data(aw_addr)
  );

  axil_chan_hold #(
    .W(WBUS_W)
  ) u_w_hold (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(s_axi_wvalid),
    .in_ready(s_axi_wready),
    .in_data({s_axi_wstrb, s_axi_wdata}),
    .clr(wr_clr),
    .full(w_full),
    .data(w_hold)
  );

  assign w_data = w_hold[31:0];
  assign w_strb = w_hold[WBUS_W-1:32];

  // ==========================================================
  // Address decode
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic wr_mapped;
  logic rd_mapped;

  function automatic logic idx_mapped(input logic [ADDR_W-1:0] addr);
    logic [7:0] idx;
    logic hi_zero;
    idx = addr[inset_geom_pkg::IDX_LSB +: inset_geom_pkg::IDX_W];
    hi_zero = (addr >> (inset_geom_pkg::IDX_LSB + inset_geom_pkg::IDX_W)) == '0;
    return hi_zero && ((idx == inset_geom_pkg::IDX_SEL)
      || ((idx >= inset_geom_pkg::IDX_IMG_W_LO)
      && (idx <= inset_geom_pkg::IDX_WIN_W_HI)));
  endfunction

  assign wr_idx = aw_addr[inset_geom_pkg::IDX_LSB +: inset_geom_pkg::IDX_W];
  assign rd_idx = s_axi_araddr[inset_geom_pkg::IDX_LSB +: inset_geom_pkg::IDX_W];
  assign wr_mapped = idx_mapped(aw_addr);
  assign rd_mapped = idx_mapped(s_axi_araddr);

  // ==========================================================
  // Write path
  wstate_t wst_q;
  wstate_t wst_d;
  logic bvalid_q;
  logic bvalid_d;
  logic [1:0] bresp_q;
  logic [1:0] bresp_d;
  logic sel_q;
  logic sel_d;
  inset_geom_pkg::wr_t wr_bus;

  always_comb
  begin
    wst_d = wst_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    sel_d = sel_q;
    wr_clr = 1'b0;
    wr_bus = '0;
    unique case (wst_q)
      WS_IDLE:
      begin
        if (aw_full && w_full)
        begin
          wr_clr = 1'b1;
          bvalid_d = 1'b1;
          bresp_d = wr_mapped ? inset_geom_pkg::RESP_OKAY
            : inset_geom_pkg::RESP_SLVERR;
          wst_d = WS_RESP;
          if (wr_mapped && w_strb[0])
          begin
            if (wr_idx == inset_geom_pkg::IDX_SEL)
            begin
              sel_d = w_data[inset_geom_pkg::SEL_BIT];
            end
            else
            begin
              wr_bus.en = 1'b1;
              wr_bus.idx = wr_idx;
              wr_bus.data = w_data[7:0];
            end
          end
        end
      end
      WS_RESP:
      begin
        if (s_axi_bready)
        begin
          bvalid_d = 1'b0;
          wst_d = WS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wst_q <= WS_IDLE;
      bvalid_q <= 1'b0;
      bresp_q <= inset_geom_pkg::RESP_OKAY;
      sel_q <= 1'b0;
    end
    else
    begin
      wst_q <= wst_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      sel_q <= sel_d;
    end
  end

  // ==========================================================
  // Inset parameter sets
  inset_geom_pkg::wr_t wr_set [NUM_INSETS];
  logic [7:0] rd_bytes [NUM_INSETS];

  for (genvar g = 0; g < NUM_INSETS; g++)
  begin : g_inset
    // Only the selected inset sees the write
    assign wr_set[g] = '{en: wr_bus.en && (sel_q == 1'(g)),
      idx: wr_bus.idx, data: wr_bus.data};

    inset_param_set u_set (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .wr(wr_set[g]),
      .rd_idx(rd_idx),
      .rd_byte(rd_bytes[g]),
      .geom(inset_geom[g])
    );
  end

  // ==========================================================
  // Read path
  rstate_t rst_q;
  rstate_t rst_d;
  logic arready_q;
  logic arready_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [1:0] rresp_q;
  logic [1:0] rresp_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] rd_word;

  // Upper bits of every register read as zero
  assign rd_word = (rd_idx == inset_geom_pkg::IDX_SEL) ? 32'(sel_q)
    : 32'(rd_bytes[sel_q]);

  always_comb
  begin
    rst_d = rst_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    unique case (rst_q)
      RS_IDLE:
      begin
        if (s_axi_arvalid)
        begin
          arready_d = 1'b0;
          rvalid_d = 1'b1;
          rresp_d = rd_mapped ? inset_geom_pkg::RESP_OKAY
            : inset_geom_pkg::RESP_SLVERR;
          rdata_d = rd_mapped ? rd_word : '0;
          rst_d = RS_DATA;
        end
      end
      RS_DATA:
      begin
        if (s_axi_rready)
        begin
          arready_d = 1'b1;
          rvalid_d = 1'b0;
          rdata_d = '0;
          rst_d = RS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_q <= RS_IDLE;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= inset_geom_pkg::RESP_OKAY;
      rdata_q <= '0;
    end
    else
    begin
      rst_q <= rst_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign inset_sel = sel_q;

  // ==========================================================
  // Checks
  logic [7:0] ylo_q;
  logic [7:0] ylo_d;

  always_comb
  begin
    ylo_d = ylo_q;
    if (wr_set[0].en && (wr_set[0].idx == inset_geom_pkg::IDX_OFFY_LO))
    begin
      ylo_d = wr_set[0].data;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ylo_q <= '0;
    end
    else
    begin
      ylo_q <= ylo_d;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_x_hi_wr0;
    wr_set[0].en && (wr_set[0].idx == inset_geom_pkg::IDX_OFFX_HI);
  endsequence

  sequence s_y_hi_wr0;
    wr_set[0].en && (wr_set[0].idx == inset_geom_pkg::IDX_OFFY_HI);
  endsequence

  sequence s_low_byte_wr;
    wr_bus.en && ((wr_bus.idx == inset_geom_pkg::IDX_IMG_W_LO)
      || (wr_bus.idx == inset_geom_pkg::IDX_OFFX_LO)
      || (wr_bus.idx == inset_geom_pkg::IDX_OFFY_LO)
      || (wr_bus.idx == inset_geom_pkg::IDX_WIN_W_LO));
  endsequence

  a_img_w_tied:
    assert property (inset_geom[0].img_w[1:0] == '0 && inset_geom[1].img_w[1:0] == '0)
    else $error("image width low bits not zero");

  a_offx_tied:
    assert property (inset_geom[0].off_x[1:0] == '0 && inset_geom[1].off_x[1:0] == '0)
    else $error("x offset low bits not zero");

  a_win_w_tied:
    assert property (inset_geom[0].win_w[1:0] == '0 && inset_geom[1].win_w[1:0] == '0)
    else $error("window width low bits not zero");

  a_offx_apply:
    assert property (s_x_hi_wr0 |=> inset_geom[0].off_x[12:8] == $past(wr_set[0].data[4:0]))
    else $error("x offset high bits not applied");

  a_offy_apply:
    assert property (s_y_hi_wr0 |=>
      inset_geom[0].off_y == {$past(wr_set[0].data[4:0]), ylo_q})
    else $error("y offset not formed from both bytes");

  a_stage_hold:
    assert property (s_low_byte_wr |=> $stable(inset_geom[0]) && $stable(inset_geom[1]))
    else $error("low byte write changed applied geometry");

  a_route_sel:
    assert property (wr_bus.en && sel_q |=> $stable(inset_geom[0]))
    else $error("write reached the unselected inset");

  a_read_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == '0)
    else $error("read data upper bits not zero");

endmodule

`default_nettype wire
